// >>> shared/tasm_pkg.sv
// constants and types for the alert and overtemperature flag logic
package tasm_pkg;
  // register addresses
  localparam logic [7:0] CONFIG_ONE_ADDR      = 8'h41;
  localparam logic [7:0] ALERT_MASK_ADDR      = 8'h42;
  localparam logic [7:0] OVERTEMP_MASK_ADDR   = 8'h43;
  localparam logic [7:0] ALERT_STATUS_ADDR    = 8'h44;
  localparam logic [7:0] OVERTEMP_STATUS_ADDR = 8'h45;
  localparam logic [7:0] FAULT_STATUS_ADDR    = 8'h46;
  // values after reset
  localparam logic [7:0] REG_RESET            = 8'h00;
  // field positions
  localparam int         CANCEL_BIT           = 3;
  localparam int         LOCAL_ALERT_BIT      = 6;
  localparam logic [7:0] OVERTEMP_USED_BITS   = 8'h39;
  localparam logic [7:0] ALERT_USED_BITS      = 8'h7f;
  localparam logic [7:0] FAULT_USED_BITS      = 8'h7e;
  // channels: 0 local, 1..6 remote
  localparam int         NUM_CHAN             = 7;
  // timing
  localparam int         CLK_HZ               = 20000000;
  localparam int         CANCEL_EXTRA_MS      = 125;
  localparam int         CANCEL_EXTRA_CYCLES  = CLK_HZ / 1000 * CANCEL_EXTRA_MS;
  localparam int         CONV_CYCLES          = 2000;
  // hysteresis in degrees, one count per degree
  localparam logic [7:0] HYST_DEG             = 8'h04;

  typedef enum logic [2:0]
  {
    TASM_IDLE = 3'b001,
    TASM_CONV = 3'b010,
    TASM_DONE = 3'b100
  } tasm_state_t;
endpackage

// >>> rtl/tasm_compare.sv
// limit comparison with hysteresis for one channel
`timescale 1ns/10ps
module tasm_compare
  import tasm_pkg::*;
(
  input  wire logic [7:0] temp_i,
  input  wire logic [7:0] limit_i,
  input  wire logic       active_i,
  output logic            hot_o
);
  logic [8:0] low_mark;

  always_comb
  begin
    low_mark = {1'b0, limit_i} - {1'b0, HYST_DEG};
    // above limit trips; stays active until below limit minus hysteresis
    if (temp_i > limit_i)
      hot_o = 1'b1;
    else if (active_i && (low_mark[8] || ({1'b0, temp_i} >= low_mark)))
      hot_o = 1'b1;
    else
      hot_o = 1'b0;
  end
endmodule

// >>> rtl/tasm_top.sv
// alert, overtemperature and diode-fault status with conversion sequencer
`timescale 1ns/10ps
module tasm_top
  import tasm_pkg::*;
#(
  parameter int CANCEL_CYCLES = CANCEL_EXTRA_CYCLES,
  parameter int CONV_LEN      = CONV_CYCLES
)
(
  input  wire logic        REF_CLK_I,
  input  wire logic        NRST_I,
  input  wire logic [7:0]  REG_ADDR_I,
  input  wire logic [7:0]  REG_WDATA_I,
  input  wire logic        REG_WR_I,
  input  wire logic        REG_RD_I,
  output logic      [7:0]  REG_RDATA_O,
  input  wire logic [55:0] CHAN_TEMP_I,
  input  wire logic [55:0] ALERT_LIMIT_I,
  input  wire logic [55:0] OVERTEMP_LIMIT_I,
  input  wire logic [6:0]  DIODE_ANODE_OPEN_I,
  input  wire logic [6:0]  DIODE_CATHODE_OPEN_I,
  input  wire logic [6:0]  DIODE_ANODE_AT_SUPPLY_I,
  output logic      [2:0]  CONV_CHAN_O,
  output logic             CONV_BUSY_O,
  output logic             ALERT_O,
  output logic             OVERTEMP_OUTPUT_O
);
  // ==========================================================
  // pin synchronisers
  logic [6:0] an_s1, an_s2, ca_s1, ca_s2, vs_s1, vs_s2;
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      an_s1 <= '0;
      an_s2 <= '0;
      ca_s1 <= '0;
      ca_s2 <= '0;
      vs_s1 <= '0;
      vs_s2 <= '0;
    end
    else
    begin
      an_s1 <= DIODE_ANODE_OPEN_I;
      an_s2 <= an_s1;
      ca_s1 <= DIODE_CATHODE_OPEN_I;
      ca_s2 <= ca_s1;
      vs_s1 <= DIODE_ANODE_AT_SUPPLY_I;
      vs_s2 <= vs_s1;
    end
  end

  // ==========================================================
  // registers and sequencer state
  logic [7:0]  config_one, alert_mask, overtemp_mask;
  logic [7:0]  alert_status, overtemp_status, fault_status;
  logic [6:0]  alert_act, over_act;
  logic        overtemp_out;
  logic [7:0]  rdata;
  tasm_state_t state;
  logic [2:0]  chan;
  logic [31:0] cnt;
  logic [7:0]  next_config_one, next_alert_mask, next_overtemp_mask;
  logic [7:0]  next_alert_status, next_overtemp_status, next_fault_status;
  logic [6:0]  next_alert_act, next_over_act;
  logic        next_overtemp_out;
  logic [7:0]  next_rdata;
  tasm_state_t next_state;
  logic [2:0]  next_chan;
  logic [31:0] next_cnt;

  logic [6:0]  fault_now, alert_hot, over_hot;

  function automatic logic [2:0] next_live(input logic [2:0] from, input logic [6:0] flt);
    logic [2:0] c;
    c = from;
    for (int k = 0; k < NUM_CHAN; k++)
    begin
      c = (c == 3'h6) ? 3'h0 : c + 3'h1;
      if (!flt[c])
        return c;
    end
    return 3'h0;
  endfunction

  assign fault_now = ((an_s2 & ca_s2) | vs_s2) & FAULT_USED_BITS[6:0];

  // ==========================================================
  // comparators
  genvar g;
  generate
    for (g = 0; g < NUM_CHAN; g++)
    begin : gen_cmp
      tasm_compare u_alert
      (
        .temp_i   (CHAN_TEMP_I[g*8 +: 8]),
        .limit_i  (ALERT_LIMIT_I[g*8 +: 8]),
        .active_i (alert_act[g]),
        .hot_o    (alert_hot[g])
      );
      tasm_compare u_over
      (
        .temp_i   (CHAN_TEMP_I[g*8 +: 8]),
        .limit_i  (OVERTEMP_LIMIT_I[g*8 +: 8]),
        .active_i (over_act[g]),
        .hot_o    (over_hot[g])
      );
    end
  endgenerate

  // ==========================================================
  // next-state logic
  always_comb
  begin
    next_config_one      = config_one;
    next_alert_mask      = alert_mask;
    next_overtemp_mask   = overtemp_mask;
    next_alert_status    = alert_status;
    next_overtemp_status = overtemp_status;
    next_fault_status    = {1'b0, fault_now};
    next_alert_act       = alert_act;
    next_over_act        = over_act;
    next_overtemp_out    = overtemp_out;
    next_state           = state;
    next_chan            = chan;
    next_cnt             = cnt;
    next_rdata           = rdata;

    if (REG_WR_I)
    begin
      case (REG_ADDR_I)
        CONFIG_ONE_ADDR:    next_config_one    = REG_WDATA_I;
        ALERT_MASK_ADDR:    next_alert_mask    = REG_WDATA_I & ALERT_USED_BITS;
        OVERTEMP_MASK_ADDR: next_overtemp_mask = REG_WDATA_I & OVERTEMP_USED_BITS;
        default:            next_config_one    = config_one;
      endcase
    end

    if (REG_RD_I)
    begin
      case (REG_ADDR_I)
        CONFIG_ONE_ADDR:      next_rdata = config_one;
        ALERT_MASK_ADDR:      next_rdata = alert_mask;
        OVERTEMP_MASK_ADDR:   next_rdata = overtemp_mask;
        ALERT_STATUS_ADDR:    next_rdata = alert_status;
        OVERTEMP_STATUS_ADDR: next_rdata = overtemp_status;
        FAULT_STATUS_ADDR:    next_rdata = fault_status;
        default:              next_rdata = REG_RESET;
      endcase
      // read clears flags and with them ALERT_O, not the overtemp output
      if (REG_ADDR_I == ALERT_STATUS_ADDR)
        next_alert_status = REG_RESET;
      if (REG_ADDR_I == OVERTEMP_STATUS_ADDR)
        next_overtemp_status = REG_RESET;
    end

    case (state)
      TASM_IDLE:
      begin
        next_chan  = next_live(3'h6, fault_now);
        next_cnt   = '0;
        // local channel never faults, so a live channel always exists
        next_state = TASM_CONV;
      end
      TASM_CONV:
      begin
        next_cnt = cnt + 32'h1;
        if ((chan == 3'h1 && config_one[CANCEL_BIT]) ?
            (cnt >= 32'(CONV_LEN + CANCEL_CYCLES - 1)) :
            (cnt >= 32'(CONV_LEN - 1)))
          next_state = TASM_DONE;
      end
      TASM_DONE:
      begin
        // compare at end of this channel's conversion
        if (!fault_now[chan])
        begin
          next_alert_act[chan] = alert_hot[chan];
          next_over_act[chan]  = over_hot[chan];
          if (alert_hot[chan])
            next_alert_status[(chan == 3'h0) ? LOCAL_ALERT_BIT : chan - 3'h1] = 1'b1;
          if (over_hot[chan] && OVERTEMP_USED_BITS[chan - 3'h1] && chan != 3'h0)
            next_overtemp_status[chan - 3'h1] = 1'b1;
        end
        next_chan  = next_live(chan, fault_now);
        next_cnt   = '0;
        next_state = TASM_CONV;
      end
      default:
        next_state = TASM_IDLE;
    endcase

    // output follows active conditions, masked
    next_overtemp_out = |(over_act[6:1] & ~overtemp_mask[5:0]
                          & OVERTEMP_USED_BITS[5:0]);
  end

  // ==========================================================
  // state registers
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      config_one      <= REG_RESET;
      alert_mask      <= REG_RESET;
      overtemp_mask   <= REG_RESET;
      alert_status    <= REG_RESET;
      overtemp_status <= REG_RESET;
      fault_status    <= REG_RESET;
      alert_act       <= '0;
      over_act        <= '0;
      overtemp_out    <= 1'b0;
      rdata           <= REG_RESET;
      state           <= TASM_IDLE;
      chan            <= 3'h0;
      cnt             <= '0;
    end
    else
    begin
      config_one      <= next_config_one;
      alert_mask      <= next_alert_mask;
      overtemp_mask   <= next_overtemp_mask;
      alert_status    <= next_alert_status;
      overtemp_status <= next_overtemp_status;
      fault_status    <= next_fault_status;
      alert_act       <= next_alert_act;
      over_act        <= next_over_act;
      overtemp_out    <= next_overtemp_out;
      rdata           <= next_rdata;
      state           <= next_state;
      chan            <= next_chan;
      cnt             <= next_cnt;
    end
  end

  // alert status bit i maps to channel: bit 6 local, bit k remote k+1
  logic [6:0] alert_chan_flags;
  assign alert_chan_flags = {alert_status[5:0], alert_status[LOCAL_ALERT_BIT]};

  always_comb
  begin
    ALERT_O = |(alert_chan_flags & ~{alert_mask[5:0], alert_mask[LOCAL_ALERT_BIT]});
  end

  assign REG_RDATA_O       = rdata;
  assign OVERTEMP_OUTPUT_O = overtemp_out;
  assign CONV_CHAN_O       = chan;
  assign CONV_BUSY_O       = (state == TASM_CONV);
endmodule

// >>> verification/tasm_checker.sv
// assertion checker for the alert and overtemperature flag logic
`timescale 1ns/10ps
module tasm_checker
  import tasm_pkg::*;
(
  input wire logic       REF_CLK_I,
  input wire logic       NRST_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic       REG_WR_I,
  input wire logic       REG_RD_I,
  input wire logic [7:0] REG_RDATA_O,
  input wire logic [6:0] DIODE_ANODE_OPEN_I,
  input wire logic [6:0] DIODE_CATHODE_OPEN_I,
  input wire logic [6:0] DIODE_ANODE_AT_SUPPLY_I,
  input wire logic [2:0] CONV_CHAN_O,
  input wire logic       CONV_BUSY_O,
  input wire logic       ALERT_O,
  input wire logic       OVERTEMP_OUTPUT_O
);
  // ==========
  // shadow of the two mask registers
  logic [7:0] amask;
  logic [7:0] omask;
  logic [7:0] next_amask;
  logic [7:0] next_omask;
  logic [6:0] flt;
  assign flt = ((DIODE_ANODE_OPEN_I & DIODE_CATHODE_OPEN_I) | DIODE_ANODE_AT_SUPPLY_I) & 7'h7e;
  always_comb
  begin
    next_amask = amask;
    next_omask = omask;
    if (REG_WR_I && REG_ADDR_I == ALERT_MASK_ADDR)
      next_amask = REG_WDATA_I & ALERT_USED_BITS;
    if (REG_WR_I && REG_ADDR_I == OVERTEMP_MASK_ADDR)
      next_omask = REG_WDATA_I & OVERTEMP_USED_BITS;
  end
  always_ff @(posedge REF_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      amask <= REG_RESET;
      omask <= REG_RESET;
    end
    else
    begin
      amask <= next_amask;
      omask <= next_omask;
    end
  end
  // ==========
  // properties
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!NRST_I);
  sequence rd_at(logic [7:0] a);
    REG_RD_I && REG_ADDR_I == a;
  endsequence
  chk_omask_read: assert property (rd_at(OVERTEMP_MASK_ADDR) |=> REG_RDATA_O == omask)
    else $error("overtemp mask readback wrong");
  chk_amask_read: assert property (rd_at(ALERT_MASK_ADDR) |=> REG_RDATA_O == amask)
    else $error("alert mask readback wrong");
  chk_alert_masked: assert property (amask == ALERT_USED_BITS |-> !ALERT_O)
    else $error("alert with all channels masked");
  chk_ot_masked: assert property ((omask == OVERTEMP_USED_BITS) [*2] |-> !OVERTEMP_OUTPUT_O)
    else $error("overtemp with all channels masked");
  chk_chan_range: assert property (CONV_BUSY_O |-> CONV_CHAN_O != 3'd7)
    else $error("conversion on no channel");
  chk_skip_fault: assert property (CONV_BUSY_O |-> !flt[CONV_CHAN_O])
    else $error("faulted channel converted");
  chk_fault_read: assert property (rd_at(FAULT_STATUS_ADDR) |=> REG_RDATA_O == {1'b0, flt})
    else $error("fault status wrong");
  chk_ot_read_keep: assert property (rd_at(OVERTEMP_STATUS_ADDR) ##0 OVERTEMP_OUTPUT_O
    && !$past(REG_WR_I) |=> OVERTEMP_OUTPUT_O)
    else $error("status read dropped overtemp");
endmodule
bind tasm_top tasm_checker u_tasm_checker (.REF_CLK_I(REF_CLK_I), .NRST_I(NRST_I),
  .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I),
  .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O), .DIODE_ANODE_OPEN_I(DIODE_ANODE_OPEN_I),
  .DIODE_CATHODE_OPEN_I(DIODE_CATHODE_OPEN_I), .CONV_CHAN_O(CONV_CHAN_O),
  .DIODE_ANODE_AT_SUPPLY_I(DIODE_ANODE_AT_SUPPLY_I), .CONV_BUSY_O(CONV_BUSY_O),
  .ALERT_O(ALERT_O), .OVERTEMP_OUTPUT_O(OVERTEMP_OUTPUT_O));

// >>> verification/tasm_host.sv
// register host model driving the block's read and write strobes
`timescale 1ns/10ps
module tasm_host
(
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  output logic      [7:0] addr_o = 8'h00,
  output logic      [7:0] wdata_o = 8'h00,
  output logic            wr_o = 1'b0,
  output logic            rd_o = 1'b0
);
  // idle address and data show the inverse of the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    addr_o  <= ~a;
    wdata_o <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clk_i);
    rd_o   <= 1'b0;
    addr_o <= ~a;
    #1;
    d = rdata_i;
  endtask
endmodule

// >>> verification/tb.sv
// self-checking testbench for the alert and overtemperature flag logic
`timescale 1ns/10ps
module tb
  import tasm_pkg::*;
;
  localparam int CONV = 10;
  localparam int CANC = 20;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  addr, wdata, rdata, d;
  logic        wr, rd, busy, alert, ot;
  logic [55:0] temp = {7{8'h50}};
  logic [55:0] alim = {7{8'h40}};
  logic [55:0] olim = {7{8'h40}};
  logic [6:0]  aopen = 7'h04;
  logic [6:0]  copen = 7'h04;
  logic [6:0]  asup = 7'h08;
  logic [2:0]  chan;
  logic [7:0]  ra [5] = '{ALERT_STATUS_ADDR, OVERTEMP_STATUS_ADDR, OVERTEMP_MASK_ADDR,
                          ALERT_MASK_ADDR, CONFIG_ONE_ADDR};
  logic [7:0]  om [4] = '{8'h38, 8'h31, 8'h29, 8'h19};
  int          err_count = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          n;
  always #25 clk = ~clk;
  tasm_top #(.CANCEL_CYCLES(CANC), .CONV_LEN(CONV)) u_tasm_top (.REF_CLK_I(clk),
    .NRST_I(nrst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd),
    .REG_RDATA_O(rdata), .CHAN_TEMP_I(temp), .ALERT_LIMIT_I(alim), .OVERTEMP_LIMIT_I(olim),
    .DIODE_ANODE_OPEN_I(aopen), .DIODE_CATHODE_OPEN_I(copen), .DIODE_ANODE_AT_SUPPLY_I(asup),
    .CONV_CHAN_O(chan), .CONV_BUSY_O(busy), .ALERT_O(alert), .OVERTEMP_OUTPUT_O(ot));
  tasm_host u_tasm_host (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd));
  // ==========
  // helpers
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    total_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    u_tasm_host.rd(a, d);
    chk8($sformatf("reg %h", a), e, d);
  endtask
  task automatic wait_ch(input logic [2:0] c);
    do
    begin
      @(posedge clk);
      #1;
    end
    while (!(busy === 1'b1 && chan === c));
  endtask
  task automatic sweep();
    wait_ch(3'd0);
    wait_ch(3'd6);
    while (busy === 1'b1) @(posedge clk);
    repeat (2) @(posedge clk);
    #1;
  endtask
  // length of one conversion of channel c
  task automatic meas(input logic [2:0] c, input int e);
    wait_ch(3'd0);
    wait_ch(c);
    n = 0;
    while (busy === 1'b1 && chan === c)
    begin
      n++;
      @(posedge clk);
      #1;
    end
    chk8($sformatf("conv length ch%0d", c), 8'(e), 8'(n));
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      err_count++;
      wrap_up();
    end
  end
  // ==========
  // tests
  initial
  begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    foreach (ra[i]) rchk(ra[i], REG_RESET);
    u_tasm_host.wr(ALERT_MASK_ADDR, 8'hff);
    u_tasm_host.wr(OVERTEMP_MASK_ADDR, 8'hff);
    rchk(ALERT_MASK_ADDR, 8'h7f);
    rchk(OVERTEMP_MASK_ADDR, 8'h39);
    sweep();
    sweep();
    chk1("alert masked", 1'b0, alert);
    chk1("overtemp masked", 1'b0, ot);
    rchk(FAULT_STATUS_ADDR, 8'h0c);
    rchk(ALERT_STATUS_ADDR, 8'h79);
    rchk(OVERTEMP_STATUS_ADDR, 8'h39);
    $display("test reset and status done");
    u_tasm_host.wr(ALERT_MASK_ADDR, 8'h79);
    sweep();
    chk1("alert faulted only", 1'b0, alert);
    u_tasm_host.wr(ALERT_MASK_ADDR, 8'h3f);
    #1;
    chk1("alert local", 1'b1, alert);
    $display("test alert mask done");
    foreach (om[i])
    begin
      u_tasm_host.wr(OVERTEMP_MASK_ADDR, om[i]);
      repeat (2) @(posedge clk);
      #1;
      chk1($sformatf("overtemp open %h", om[i]), 1'b1, ot);
      u_tasm_host.rd(OVERTEMP_STATUS_ADDR, d);
      chk1("overtemp after read", 1'b1, ot);
      u_tasm_host.wr(OVERTEMP_MASK_ADDR, 8'h39);
      repeat (2) @(posedge clk);
      #1;
      chk1($sformatf("overtemp shut %h", om[i]), 1'b0, ot);
    end
    $display("test overtemp mask done");
    u_tasm_host.wr(OVERTEMP_MASK_ADDR, 8'h38);
    @(posedge clk);
    temp <= {7{8'h3e}};
    sweep();
    chk1("overtemp in band", 1'b1, ot);
    @(posedge clk);
    temp <= {7{8'h3b}};
    sweep();
    chk1("overtemp cooled", 1'b0, ot);
    rchk(OVERTEMP_STATUS_ADDR, 8'h39);
    rchk(OVERTEMP_STATUS_ADDR, 8'h00);
    rchk(ALERT_STATUS_ADDR, 8'h79);
    chk1("alert after status read", 1'b0, alert);
    $display("test hysteresis done");
    meas(3'd1, CONV);
    meas(3'd4, CONV);
    u_tasm_host.wr(CONFIG_ONE_ADDR, 8'h08);
    rchk(CONFIG_ONE_ADDR, 8'h08);
    meas(3'd1, CONV + CANC);
    meas(3'd4, CONV);
    $display("test cancellation done");
    wrap_up();
  end
endmodule
